// *** pkg/bwu_pkg.sv ***
// Constants, register map and state encodings for the bandwidth update request builder.
// Assumes a single 125 MHz clock and an AXI4-Lite register port with 32-bit data.
`default_nettype none
package bwu_pkg;
  localparam int AXI_AW = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_REPORTER = 12'h004;
  localparam logic [11:0] REG_DCOUNT = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  // Table window: one 32-bit word per entry
  localparam logic [3:0] TABLE_PAGE = 4'h1;
  localparam int CTRL_START = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_WAIT = 1;
  localparam int ST_RETRY = 2;
  localparam int ST_HOLD = 3;
  localparam int ST_REFUSED = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] RESET_REPORTER = 8'h00;
  localparam logic [7:0] RESET_DCOUNT = 8'h00;
  // Payload layout
  localparam int OFS_REPORTER = 0;
  localparam int OFS_DCOUNT = 1;
  localparam int OFS_FIRST_DEST = 2;
  localparam int OFS_QCOUNT = 0;
  localparam int OFS_FIRST_REC = 1;
  localparam int OFS_FIRST_BWV = 3;
  localparam logic [1:0] WORD_LAST_OCTET = 2'h3;
  // Timing
  localparam int CLK_NS = 8;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_NS / CLK_NS;
  localparam int RETRY_MS = 200;
  localparam int HOLDOFF_MS = 1000;
  localparam int TABLE_DEPTH = 64;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_REP = 3'b001,
    S_CNT = 3'b010,
    S_FETCH = 3'b011,
    S_LOAD = 3'b100,
    S_EMIT = 3'b101,
    S_QCNT = 3'b110
  } build_state_t;

  typedef enum logic [1:0] {
    K_DEST = 2'b00,
    K_RATE = 2'b01,
    K_REC = 2'b10
  } word_kind_t;
endpackage
`default_nettype wire

// *** pkg/octet_stream_if.sv ***
// Valid/ready stream carrying one payload octet plus an end-of-payload flag.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface octet_stream_if #(parameter int W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// *** hw/table_ram.sv ***
// Report table storage: byte-writable, one read port with registered read data.
// Assumes one clock; no reset on the array itself.
`timescale 1ns/10ps
`default_nettype none
module table_ram #(
  parameter int DEPTH = bwu_pkg::TABLE_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [3:0] wstrb,
  input wire logic [AW-1:0] waddr,
  input wire logic [31:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem [DEPTH];

  for (genvar b = 0; b < 4; b++) begin : g_lane
    always_ff @(posedge clk) begin
      if (we && wstrb[b]) begin
        mem[waddr][8*b +: 8] <= wdata[8*b +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// *** hw/pair_buffer.sv ***
// Two-entry FIFO between the framer and the payload port.
// Assumes the sink may hold ready low for any time; nothing is dropped.
`timescale 1ns/10ps
`default_nettype none
module pair_buffer #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Filling side
  octet_stream_if.snk fill,
  // Draining side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    logic [1:0][W-1:0] d;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } buf_t;
  buf_t r, n;
  logic put, take;

  assign fill.ready = r.cnt != 2'h2;
  assign out_valid = r.cnt != 2'h0;
  assign out_data = r.d[r.rp];
  assign put = fill.valid && fill.ready;
  assign take = out_valid && out_ready;

  always_comb begin
    n = r;
    if (put) begin
      n.d[r.wp] = fill.data;
      n.wp = ~r.wp;
    end
    if (take) begin
      n.rp = ~r.rp;
    end
    n.cnt = r.cnt + {1'b0, put} - {1'b0, take};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  a_buf_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cnt == 2'h2 && !out_ready |=> r.cnt == 2'h2 && out_data == $past(out_data))
    else $error("full buffer changed while stalled");
  a_buf_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    put && r.cnt == 2'h0 |=> out_valid && out_data == $past(fill.data))
    else $error("octet not passed through empty buffer");
endmodule
`default_nettype wire

// *** hw/bwu_builder.sv ***
// Builds the bandwidth update request payload as an octet stream from a software table.
// Assumes AXI4-Lite masters and the confirm pulse share aclk.
`timescale 1ns/10ps
`default_nettype none
module bwu_builder
  import bwu_pkg::*;
#(
  parameter int TICK_CYCLES = bwu_pkg::TICK_CYCLES_DEF,
  parameter int RETRY_LEN = bwu_pkg::RETRY_MS,
  parameter int HOLD_LEN = bwu_pkg::HOLDOFF_MS,
  parameter int DEPTH = bwu_pkg::TABLE_DEPTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [bwu_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [bwu_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Confirm from the domain master
  input wire logic bandwidth_update_confirm,
  // Payload octets
  output logic [7:0] payload_data,
  output logic payload_last,
  output logic payload_valid,
  input wire logic payload_ready
);
  import bwu_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    build_state_t st;
    word_kind_t kind;
    logic [AW-1:0] addr;
    logic [31:0] word;
    logic [1:0] bleft;
    logic [7:0] dleft;
    logic [7:0] qleft;
    logic [15:0] pos;
    logic [7:0] rep;
    logic [7:0] dcnt;
    logic waiting;
    logic retry_ok;
    logic hold;
    logic refused;
    logic [31:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic aw_ok;
    logic [11:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } regs_t;

  regs_t r, n;
  logic push, tick, wr_go, start_wr, clr_wr, accept, tbl_we, dest_done, frame_done;
  logic [31:0] tbl_rdata;
  logic [7:0] byte_out;
  logic last_out;

  octet_stream_if #(.W(9)) so();

  table_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
    .clk(aclk),
    .we(tbl_we),
    .wstrb(r.wstrb),
    .waddr(r.awaddr[AW+1:2]),
    .wdata(r.wdata),
    .raddr(r.addr),
    .rdata(tbl_rdata)
  );

  pair_buffer #(.W(9)) u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .fill(so.snk),
    .out_data({payload_last, payload_data}),
    .out_valid(payload_valid),
    .out_ready(payload_ready)
  );

  assign so.valid = r.st == S_REP || r.st == S_CNT || r.st == S_EMIT || r.st == S_QCNT;
  assign so.data = {last_out, byte_out};
  assign push = so.valid && so.ready;
  assign s_axi_awready = !r.aw_ok;
  assign s_axi_wready = !r.w_ok;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  always_comb begin
    n = r;
    byte_out = 8'h00;
    last_out = 1'b0;
    dest_done = 1'b0;
    frame_done = 1'b0;
    tick = r.tick_cnt == 32'(TICK_CYCLES - 1);
    wr_go = r.aw_ok && r.w_ok && !r.bvalid;
    start_wr = wr_go && r.awaddr == REG_CTRL && r.wstrb[0] && r.wdata[CTRL_START];
    clr_wr = wr_go && r.awaddr == REG_STATUS && r.wstrb[0] && r.wdata[ST_REFUSED];
    tbl_we = wr_go && r.awaddr[11:8] == TABLE_PAGE && 32'(r.awaddr[7:2]) < DEPTH;

    // Write channel: address and data may arrive in either order
    if (s_axi_awvalid && !r.aw_ok) begin
      n.aw_ok = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_ok) begin
      n.w_ok = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      if (r.awaddr == REG_REPORTER) begin
        if (r.wstrb[0]) n.rep = r.wdata[7:0];
      end else if (r.awaddr == REG_DCOUNT) begin
        if (r.wstrb[0]) n.dcnt = r.wdata[7:0];
      end else if (r.awaddr != REG_CTRL && r.awaddr != REG_STATUS && !tbl_we) begin
        n.bresp = RESP_SLVERR;
      end
    end

    // Read channel; the table is write-only and reads as zero
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0000_0000;
      if (s_axi_araddr == REG_REPORTER) begin
        n.rdata[7:0] = r.rep;
      end else if (s_axi_araddr == REG_DCOUNT) begin
        n.rdata[7:0] = r.dcnt;
      end else if (s_axi_araddr == REG_STATUS) begin
        n.rdata[4:0] = {r.refused, r.hold, r.retry_ok, r.waiting, r.st != S_IDLE};
      end else if (s_axi_araddr != REG_CTRL && s_axi_araddr[11:8] != TABLE_PAGE) begin
        n.rresp = RESP_SLVERR;
      end
    end

    // Millisecond divider and report timers
    n.tick_cnt = tick ? 32'h0000_0000 : r.tick_cnt + 32'h0000_0001;
    if (tick && r.hold) begin
      if (r.ms_cnt == 16'(HOLD_LEN - 1)) begin
        n.hold = 1'b0;
        n.ms_cnt = 16'h0000;
      end else begin
        n.ms_cnt = r.ms_cnt + 16'h0001;
      end
    end else if (tick && r.waiting && !r.retry_ok) begin
      if (r.ms_cnt == 16'(RETRY_LEN - 1)) begin
        n.retry_ok = 1'b1;
      end else begin
        n.ms_cnt = r.ms_cnt + 16'h0001;
      end
    end
    if (bandwidth_update_confirm && r.waiting) begin
      n.waiting = 1'b0;
      n.retry_ok = 1'b0;
      n.hold = 1'b1;
      n.ms_cnt = 16'h0000;
      n.tick_cnt = 32'h0000_0000;
    end

    // A start is taken only when idle, out of hold-off, and not awaiting a confirm unless the retry time has run out;
    // a confirm in the same cycle already counts, so the hold-off wins
    accept = start_wr && r.st == S_IDLE && !r.hold && (!r.waiting || r.retry_ok)
      && !(bandwidth_update_confirm && r.waiting);
    if (clr_wr) n.refused = 1'b0;
    if (start_wr && !accept) n.refused = 1'b1;

    if (push) n.pos = r.pos + 16'h0001;

    unique case (r.st)
      S_IDLE: begin
        if (accept) begin
          n.st = S_REP;
          n.pos = 16'h0000;
          n.dleft = r.dcnt;
          n.addr = '0;
          n.waiting = 1'b0;
          n.retry_ok = 1'b0;
        end
      end
      S_REP: begin
        byte_out = r.rep;
        if (so.ready) n.st = S_CNT;
      end
      S_CNT: begin
        byte_out = r.dcnt;
        last_out = r.dcnt == 8'h00;
        if (so.ready) begin
          n.kind = K_DEST;
          n.st = S_FETCH;
          frame_done = r.dcnt == 8'h00;
        end
      end
      S_FETCH: begin
        n.st = S_LOAD;
      end
      S_LOAD: begin
        // One table word per destination header, rate or record, sent high octet first
        n.word = tbl_rdata;
        n.addr = r.addr + 1'b1;
        n.bleft = r.kind == K_DEST ? 2'h0 : WORD_LAST_OCTET;
        if (r.kind == K_DEST) n.qleft = tbl_rdata[23:16];
        n.st = S_EMIT;
      end
      S_EMIT: begin
        byte_out = r.word[31:24];
        last_out = r.kind == K_REC && r.bleft == 2'h0 && r.qleft == 8'h01 && r.dleft == 8'h01;
        if (so.ready) begin
          n.word = {r.word[23:0], 8'h00};
          n.bleft = r.bleft - 2'h1;
          if (r.bleft == 2'h0) begin
            unique case (r.kind)
              K_DEST: begin
                n.kind = K_RATE;
                n.st = S_FETCH;
              end
              K_RATE: n.st = S_QCNT;
              K_REC: begin
                n.qleft = r.qleft - 8'h01;
                n.st = S_FETCH;
                dest_done = r.qleft == 8'h01;
              end
              default: n.st = S_IDLE;
            endcase
          end
        end
      end
      S_QCNT: begin
        byte_out = r.qleft;
        last_out = r.qleft == 8'h00 && r.dleft == 8'h01;
        if (so.ready) begin
          n.kind = K_REC;
          n.st = S_FETCH;
          dest_done = r.qleft == 8'h00;
        end
      end
      default: n.st = S_IDLE;
    endcase

    if (dest_done) begin
      n.dleft = r.dleft - 8'h01;
      n.kind = K_DEST;
      frame_done = r.dleft == 8'h01;
    end
    if (frame_done) begin
      n.st = S_IDLE;
      n.waiting = 1'b1;
      n.retry_ok = 1'b0;
      n.ms_cnt = 16'h0000;
      n.tick_cnt = 32'h0000_0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_hdr_reporter: assert property (push && r.pos == 16'h0000 |-> byte_out == r.rep)
    else $error("first octet is not the reporter id");
  a_hdr_count: assert property (push && r.pos == 16'h0001 |-> byte_out == r.dcnt)
    else $error("second octet is not the destination count");
  a_first_dest: assert property (
    push && r.pos == 16'h0002 |-> r.st == S_EMIT && r.kind == K_DEST && r.addr == AW'(1))
    else $error("octet 2 is not the first destination id");
  a_qcount_head: assert property (push && r.st == S_QCNT |-> ##1 r.st == S_FETCH || r.st == S_IDLE)
    else $error("queue count not followed by records or end");
  a_octets_flow: assert property (
    r.st == S_EMIT && !so.ready
    |=> r.st == S_EMIT && r.word == $past(r.word) && r.bleft == $past(r.bleft))
    else $error("framer moved on while the buffer was full");
  a_hold_refuse: assert property (start_wr && r.hold |=> r.st == S_IDLE && r.refused)
    else $error("report started during hold-off");
  a_confirm_hold: assert property (
    bandwidth_update_confirm && r.waiting |=> r.hold && !r.waiting && r.ms_cnt == 16'h0000)
    else $error("confirm did not start hold-off");
  a_hold_length: assert property ($fell(r.hold) |-> $past(r.ms_cnt) == 16'(HOLD_LEN - 1))
    else $error("hold-off ended early");
  a_retry_length: assert property ($rose(r.retry_ok) |-> r.ms_cnt == 16'(RETRY_LEN - 1))
    else $error("retry allowed before the timeout");
  a_last_wait: assert property (push && last_out |=> r.st == S_IDLE && r.waiting)
    else $error("frame end did not arm the confirm wait");
  a_refused_sticky: assert property (start_wr && !accept |=> r.refused)
    else $error("refused start not flagged");
endmodule
`default_nettype wire

// *** verification/master_model.sv ***
// Domain master stand-in: takes payload octets and confirms whole frames.
// Assumes the bench chooses the stall pattern and whether frames are confirmed.
`timescale 1ns/10ps
`default_nettype none
module master_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control from the bench
  input wire logic slow,
  input wire logic ack_en,
  // Payload side
  input wire logic payload_valid,
  input wire logic payload_last,
  output logic payload_ready,
  output logic bandwidth_update_confirm
);
  logic [1:0] cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 2'h0;
      bandwidth_update_confirm <= 1'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      // A frame is confirmed only once its last octet is taken
      bandwidth_update_confirm <= ack_en && payload_valid && payload_ready && payload_last;
    end
  end
  // Slow mode takes one octet in four, so the buffer fills and refuses
  assign payload_ready = !slow || (cnt_r == 2'h3);
endmodule
`default_nettype wire

// *** verification/bandwidth_update_request_builder_tb.sv ***
// Self-checking bench for the report builder: AXI4-Lite tasks and frame checks.
// Assumes master_model on the payload port and shortened timer parameters.
`timescale 1ns/10ps
`default_nettype none
module bandwidth_update_request_builder_tb;
  import bwu_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] awaddr = 12'h0;
  logic awvalid = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic [11:0] araddr = 12'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [3:0] wstrb = 4'hF;
  // Protection bits are ignored by the design; a non-zero value shows that
  logic [2:0] prot = 3'h5;
  logic slow = 1'h1;
  logic ack_en = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, confirm, plast, pvalid, pready;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pdata;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [8:0] got[$];
  logic [7:0] exp[$];
  logic [31:0] tbl[6] = '{32'h1102_0000, 32'h0102_0304, 32'h0081_0000, 32'h0140_BEEF,
    32'h2200_0000, 32'hCAFE_0001};
  logic [7:0] f1[22] = '{8'hA5, 8'h02, 8'h11, 8'h01, 8'h02, 8'h03, 8'h04, 8'h02, 8'h00,
    8'h81, 8'h00, 8'h00, 8'h01, 8'h40, 8'hBE, 8'hEF, 8'h22, 8'hCA, 8'hFE, 8'h00, 8'h01, 8'h00};

  bwu_builder #(.TICK_CYCLES(10), .RETRY_LEN(3), .HOLD_LEN(5), .DEPTH(64)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(prot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bandwidth_update_confirm(confirm),
    .payload_data(pdata), .payload_last(plast), .payload_valid(pvalid),
    .payload_ready(pready)
  );

  master_model partner (
    .aclk(aclk), .aresetn(aresetn), .slow(slow), .ack_en(ack_en),
    .payload_valid(pvalid), .payload_last(plast), .payload_ready(pready),
    .bandwidth_update_confirm(confirm)
  );

  initial begin
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (pvalid && pready) got.push_back({plast, pdata});
  end

  task automatic results;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rchk(input logic [11:0] a, input logic [1:0] er, input logic [31:0] m,
    input logic [31:0] e, input string nm);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk(nm, e, rdata & m);
  endtask

  task automatic frame(input string nm);
    int t;
    t = 0;
    while (got.size() < exp.size() && t < 2000) begin
      @(posedge aclk);
      t++;
    end
    chk({nm, " length"}, 32'(exp.size()), 32'(got.size()));
    for (int i = 0; i < exp.size() && i < got.size(); i++) begin
      chk(nm, {23'h0, i == exp.size() - 1, exp[i]}, {23'h0, got[i]});
    end
    got.delete();
    exp.delete();
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rchk(REG_REPORTER, RESP_OKAY, 32'hFFFF_FFFF, 32'h0, "reporter");
    rchk(REG_DCOUNT, RESP_OKAY, 32'hFFFF_FFFF, 32'h0, "dcount");
    rchk(REG_STATUS, RESP_OKAY, 32'hFFFF_FFFF, 32'h0, "status");
    rchk(12'h200, RESP_SLVERR, 32'hFFFF_FFFF, 32'h0, "unmapped");
    wr(12'h204, 32'h1, RESP_SLVERR);
    wr(REG_REPORTER, 32'hA5, RESP_OKAY);
    wr(REG_DCOUNT, 32'h2, RESP_OKAY);
    rchk(REG_DCOUNT, RESP_OKAY, 32'hFFFF_FFFF, 32'h2, "dcount");
    // Byte lane 0 off: the write is answered but leaves the register alone
    wstrb <= 4'h0;
    wr(REG_REPORTER, 32'h3C, RESP_OKAY);
    wstrb <= 4'hF;
    rchk(REG_REPORTER, RESP_OKAY, 32'hFFFF_FFFF, 32'hA5, "reporter");
    for (int i = 0; i < 6; i++) begin
      wr({TABLE_PAGE, 6'(i), 2'h0}, tbl[i], RESP_OKAY);
    end
    // The table is write-only and reads back as zero
    rchk({TABLE_PAGE, 8'h04}, RESP_OKAY, 32'hFFFF_FFFF, 32'h0, "table read");
    // Slow sink, zero bandwidth value, k=0 group and a start while busy
    foreach (f1[i]) exp.push_back(f1[i]);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    frame("frame");
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    rchk(REG_STATUS, RESP_OKAY, 32'hFFFF_FFFF, 32'h12, "status");
    wr(REG_STATUS, 32'h10, RESP_OKAY);
    rchk(REG_STATUS, RESP_OKAY, 32'hFFFF_FFFF, 32'h2, "status");
    chk("early frame", 32'h0, 32'(got.size()));
    repeat (40) @(posedge aclk);
    rchk(REG_STATUS, RESP_OKAY, 32'hFFFF_FFFF, 32'h6, "status");
    // Retry with an empty destination list, confirmed by the master
    slow <= 1'h0;
    ack_en <= 1'h1;
    wr(REG_DCOUNT, 32'h0, RESP_OKAY);
    exp.push_back(8'hA5);
    exp.push_back(8'h00);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    frame("retry frame");
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    rchk(REG_STATUS, RESP_OKAY, 32'h18, 32'h18, "hold status");
    wr(REG_STATUS, 32'h10, RESP_OKAY);
    chk("held frame", 32'h0, 32'(got.size()));
    repeat (60) @(posedge aclk);
    exp.push_back(8'hA5);
    exp.push_back(8'h00);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    frame("after hold");
    rchk(REG_CTRL, RESP_OKAY, 32'hFFFF_FFFF, 32'h0, "ctrl");
    results();
  end
endmodule
`default_nettype wire
